// ### logic/usb_irq_enable_defines.vh
// register offsets, field positions and reset values of the interrupt block
`ifndef USB_IRQ_ENABLE_DEFINES_VH
`define USB_IRQ_ENABLE_DEFINES_VH

// byte offsets on the register bus
`define OFS_MODE 8'h0C
`define OFS_IRQ_CONFIG 8'h10
`define OFS_IRQ_ENABLE 8'h14
`define OFS_IRQ_STATUS 8'h18
`define OFS_IRQ_PENDING 8'h1C

// mode register
`define MODE_GLOBAL_IRQ_ENABLE_BIT 0
`define MODE_RESET 32'h00000000

// interrupt configuration register, two-bit handshake select fields
`define CFG_CTRL_SEL_LSB 0
`define CFG_DATA_IN_SEL_LSB 2
`define CFG_DATA_OUT_SEL_LSB 4
`define CFG_USED_MASK 32'h0000003F
`define CFG_RESET 32'h00000000
// select field: bit 0 passes ACK handshakes, bit 1 passes NAK handshakes
`define SEL_ACK_BIT 0
`define SEL_NAK_BIT 1

// enable and status share one layout
`define BIT_BUS_RESET 0
`define BIT_SOF 1
`define BIT_SUSPEND 2
`define BIT_RESUME 3
`define BIT_SETUP 4
`define BIT_HS_STATUS 5
`define BIT_EP_BASE 16
`define ENABLE_RESET 32'h00000000
`define ENABLE_AFTER_BUS_RESET 32'h00000001
`define STATUS_RESET 32'h00000000
`define RDATA_RESET 32'h00000000
`define IRQ_RESET 1'b0

`endif

// ### logic/handshake_qualify.v
// selects whether a handshake seen by the serial engine raises an interrupt
`timescale 1ns/100ps
`include "usb_irq_enable_defines.vh"
module handshake_qualify #(
	parameter EP_BITS = 3
) (
	input wire hsValid,
	input wire [EP_BITS-1:0] hsEp,
	input wire hsIn,
	input wire hsSetup,
	input wire hsNak,
	input wire [1:0] ctrlSel,
	input wire [1:0] dataInSel,
	input wire [1:0] dataOutSel,
	output wire rxHit,
	output wire txHit
);

	wire isCtrl;
	wire [1:0] sel;
	wire pass;

	// endpoint zero answers to its own field for in, out and setup
	assign isCtrl = (hsEp == {EP_BITS{1'b0}});
	// in goes by transmit buffers out by receive buffers
	assign sel = isCtrl ? ctrlSel : (hsIn ? dataInSel : dataOutSel);
	assign pass = hsNak ? sel[`SEL_NAK_BIT] : sel[`SEL_ACK_BIT];
	// setup data arrives like out data, so it lands on the receive bit
	assign rxHit = hsValid & pass & (hsSetup | ~hsIn);
	assign txHit = hsValid & pass & ~hsSetup & hsIn;

endmodule

// ### logic/usb_irq_enable.v
// interrupt enable, status and masking for the usb peripheral, apb slave
//
// Contract
// - separate receive and transmit enable per endpoint
// - cleared global enable suppresses every interrupt
// - ack or nak handshake raises endpoint interrupt
// - data in uses transmit, in select field
// - data out uses receive, out select field
// - endpoint zero uses control select field
// - separate enable for each bus event
// - bus reset clears enables except bus reset
// - enable register is 32 bits at 14h
//
// Local design decision: the APB slave port.
`timescale 1ns/100ps
`include "usb_irq_enable_defines.vh"
module usb_irq_enable #(
	parameter EP_COUNT = 8,
	parameter EP_BITS = 3
) (
	input wire ref_clk,
	input wire reset_n,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output wire pready,
	output wire pslverr,
	output wire [31:0] prdata,
	input wire busResetEvt,
	input wire sofEvt,
	input wire suspendEvt,
	input wire resumeEvt,
	input wire setupEvt,
	input wire hsStatusEvt,
	input wire hsValid,
	input wire [EP_BITS-1:0] hsEp,
	input wire hsIn,
	input wire hsSetup,
	input wire hsNak,
	output wire irq
);

	////////////////////////////////////////////////////////////////////////
	// declarations

	reg [31:0] mode_r;
	reg [31:0] mode_nxt;
	reg [31:0] config_r;
	reg [31:0] config_nxt;
	reg [31:0] enable_r;
	reg [31:0] enable_nxt;
	reg [31:0] status_r;
	reg [31:0] status_nxt;
	reg [31:0] rdata_r;
	reg [31:0] rdata_nxt;
	reg irq_r;
	reg hitMode;
	reg hitConfig;
	reg hitEnable;
	reg hitStatus;
	reg hitPending;
	reg mapped;
	wire setupPhase;
	wire writeAccess;
	wire globalEnable;
	wire rxHit;
	wire txHit;
	wire [1:0] controlSel;
	wire [1:0] dataInSel;
	wire [1:0] dataOutSel;
	wire wrMode;
	wire wrConfig;
	wire wrEnable;
	wire wrStatus;
	wire readSetup;
	wire [31:0] eventSet;
	wire [31:0] pending;
	wire [EP_COUNT-1:0] epRxSet;
	wire [EP_COUNT-1:0] epTxSet;

	////////////////////////////////////////////////////////////////////////
	// apb handshake
	// the slave never stalls, so every access phase ends on its first cycle

	assign pready = 1'b1;
	assign setupPhase = psel & ~penable;
	assign writeAccess = psel & penable & pwrite & mapped;
	assign pslverr = psel & penable & ~mapped;
	assign prdata = rdata_r;

	////////////////////////////////////////////////////////////////////////
	// address decode

	always @* begin
		hitMode = 1'b0;
		hitConfig = 1'b0;
		hitEnable = 1'b0;
		hitStatus = 1'b0;
		hitPending = 1'b0;
		if (paddr == `OFS_MODE) begin
			hitMode = 1'b1;
		end else if (paddr == `OFS_IRQ_CONFIG) begin
			hitConfig = 1'b1;
		end else if (paddr == `OFS_IRQ_ENABLE) begin
			hitEnable = 1'b1;
		end else if (paddr == `OFS_IRQ_STATUS) begin
			hitStatus = 1'b1;
		end else if (paddr == `OFS_IRQ_PENDING) begin
			hitPending = 1'b1;
		end
		mapped = hitMode | hitConfig | hitEnable | hitStatus | hitPending;
	end

	////////////////////////////////////////////////////////////////////////
	// register strobes
	// unmapped offsets never strobe, so such writes are simply dropped

	assign wrMode = writeAccess & hitMode;
	assign wrConfig = writeAccess & hitConfig;
	assign wrEnable = writeAccess & hitEnable;
	assign wrStatus = writeAccess & hitStatus;
	assign readSetup = setupPhase & ~pwrite;

	////////////////////////////////////////////////////////////////////////
	// handshake qualification

	// select fields split out of the configuration word
	assign controlSel =
		config_r[`CFG_CTRL_SEL_LSB+1:`CFG_CTRL_SEL_LSB];
	assign dataInSel =
		config_r[`CFG_DATA_IN_SEL_LSB+1:`CFG_DATA_IN_SEL_LSB];
	assign dataOutSel =
		config_r[`CFG_DATA_OUT_SEL_LSB+1:`CFG_DATA_OUT_SEL_LSB];

	handshake_qualify #(
		.EP_BITS(EP_BITS)
	) handshake_qualify_inst (
		.hsValid(hsValid),
		.hsEp(hsEp),
		.hsIn(hsIn),
		.hsSetup(hsSetup),
		.hsNak(hsNak),
		.ctrlSel(controlSel),
		.dataInSel(dataInSel),
		.dataOutSel(dataOutSel),
		.rxHit(rxHit),
		.txHit(txHit)
	);

	////////////////////////////////////////////////////////////////////////
	// event vector, same layout as enable and status

	genvar n;
	generate
		for (n = 0; n < 16; n = n + 1) begin : gEndpoint
			if (n < 2 * EP_COUNT && n % 2 == 0) begin : gRx
				// one receive bit per endpoint
				assign epRxSet[n/2] = rxHit & (hsEp == n / 2);
				assign eventSet[`BIT_EP_BASE+n] = epRxSet[n/2];
			end else if (n < 2 * EP_COUNT) begin : gTx
				// and one transmit bit per endpoint
				assign epTxSet[n/2] = txHit & (hsEp == n / 2);
				assign eventSet[`BIT_EP_BASE+n] = epTxSet[n/2];
			end else begin : gNone
				assign eventSet[`BIT_EP_BASE+n] = 1'b0;
			end
		end
	endgenerate

	// each bus event has a bit of its own
	assign eventSet[`BIT_BUS_RESET] = busResetEvt;
	assign eventSet[`BIT_SOF] = sofEvt;
	assign eventSet[`BIT_SUSPEND] = suspendEvt;
	assign eventSet[`BIT_RESUME] = resumeEvt;
	assign eventSet[`BIT_SETUP] = setupEvt;
	assign eventSet[`BIT_HS_STATUS] = hsStatusEvt;
	assign eventSet[`BIT_EP_BASE-1:`BIT_HS_STATUS+1] = 10'h000;

	////////////////////////////////////////////////////////////////////////
	// mode and configuration registers

	assign globalEnable = mode_r[`MODE_GLOBAL_IRQ_ENABLE_BIT];

	// unused mode bits always read back as zero
	always @* begin
		mode_nxt = mode_r;
		if (wrMode) begin
			mode_nxt = `MODE_RESET;
			mode_nxt[`MODE_GLOBAL_IRQ_ENABLE_BIT] =
				pwdata[`MODE_GLOBAL_IRQ_ENABLE_BIT];
		end
	end

	always @* begin
		config_nxt = config_r;
		if (wrConfig) begin
			config_nxt = pwdata & `CFG_USED_MASK;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// enable register
	// a bus reset beats a firmware write in the same cycle, so the
	// enable state after a reset never depends on a racing write

	always @* begin
		enable_nxt = enable_r;
		if (busResetEvt) begin
			enable_nxt = `ENABLE_AFTER_BUS_RESET;
		end else if (wrEnable) begin
			enable_nxt = pwdata;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// status register, write one to clear
	// a new event in the clearing cycle stays set

	always @* begin
		status_nxt = status_r;
		if (wrStatus) begin
			status_nxt = status_r & ~pwdata;
		end
		status_nxt = status_nxt | eventSet;
	end

	////////////////////////////////////////////////////////////////////////
	// interrupt output

	// status only latches; masking happens at the output so that
	// firmware can still poll sources it keeps disabled
	assign pending = status_r & enable_r & {32{globalEnable}};

	////////////////////////////////////////////////////////////////////////
	// read data, captured in the setup phase

	always @* begin
		rdata_nxt = rdata_r;
		if (readSetup) begin
			if (hitMode) begin
				rdata_nxt = mode_r;
			end else if (hitConfig) begin
				rdata_nxt = config_r;
			end else if (hitEnable) begin
				rdata_nxt = enable_r;
			end else if (hitStatus) begin
				rdata_nxt = status_r;
			end else if (hitPending) begin
				rdata_nxt = pending;
			end else begin
				rdata_nxt = 32'h00000000;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// flip-flops

	// one process per register keeps each reset value beside its state
	always @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			mode_r <= `MODE_RESET;
		end else begin
			mode_r <= mode_nxt;
		end
	end

	always @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			config_r <= `CFG_RESET;
		end else begin
			config_r <= config_nxt;
		end
	end

	always @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			enable_r <= `ENABLE_RESET;
		end else begin
			enable_r <= enable_nxt;
		end
	end

	always @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			status_r <= `STATUS_RESET;
		end else begin
			status_r <= status_nxt;
		end
	end

	always @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			rdata_r <= `RDATA_RESET;
		end else begin
			rdata_r <= rdata_nxt;
		end
	end

	// irq is registered from the next-state values, so it changes on the same edge as the registers, glitch free
	always @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			irq_r <= `IRQ_RESET;
		end else begin
			irq_r <= |(status_nxt & enable_nxt) &
				mode_nxt[`MODE_GLOBAL_IRQ_ENABLE_BIT];
		end
	end

	assign irq = irq_r;

endmodule

// ### test/usb_irq_enable_props.sv
// concurrent checks on the interrupt enable block ports
`timescale 1ns/100ps
module usb_irq_enable_props #(
	parameter EP_BITS = 3
) (
	input logic ref_clk,
	input logic reset_n,
	input logic psel,
	input logic penable,
	input logic pwrite,
	input logic [7:0] paddr,
	input logic [31:0] pwdata,
	input logic [31:0] prdata,
	input logic busResetEvt,
	input logic sofEvt,
	input logic hsValid,
	input logic [EP_BITS-1:0] hsEp,
	input logic hsIn,
	input logic hsNak,
	input logic irq
);
	// shadows of the writable controls, so masking can be predicted
	logic on_r;
	logic [31:0] en_r;
	logic [5:0] cfg_r;
	wire wr = psel && penable && pwrite;
	always @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			on_r <= 1'h0;
			en_r <= 32'h00000000;
			cfg_r <= 6'h00;
		end else begin
			if (wr && paddr == 8'h0C)
				on_r <= pwdata[0];
			if (busResetEvt)
				en_r <= 32'h00000001;
			else if (wr && paddr == 8'h14)
				en_r <= pwdata;
			if (wr && paddr == 8'h10)
				cfg_r <= pwdata[5:0];
		end
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	////////////////////////////////////////////////////////////
	property p_glob; !on_r |-> !irq; endproperty
	a_glob: assert property (p_glob) else $error("irq while off");
	property p_need; irq |-> on_r && en_r != 32'h00000000; endproperty
	a_need: assert property (p_need) else $error("irq unmasked");
	property p_brst; busResetEvt && on_r |=> irq; endproperty
	a_brst: assert property (p_brst) else $error("no reset irq");
	property p_sof; sofEvt && on_r && en_r[1] |=> irq; endproperty
	a_sof: assert property (p_sof) else $error("no sof irq");
	property p_rden; psel && penable && !pwrite && paddr == 8'h14
		&& !$past(busResetEvt) |-> prdata == en_r; endproperty
	a_rden: assert property (p_rden) else $error("enable readback");
	property p_ctl; hsValid && hsEp == 0 && cfg_r[hsNak] && on_r
		&& en_r[16 + hsIn] |=> irq; endproperty
	a_ctl: assert property (p_ctl) else $error("no ep0 irq");
	property p_din; hsValid && hsEp != 0 && hsIn && cfg_r[2 + hsNak]
		&& on_r && en_r[17 + 2 * hsEp] |=> irq; endproperty
	a_din: assert property (p_din) else $error("no in irq");
	property p_dout; hsValid && hsEp != 0 && !hsIn && cfg_r[4 + hsNak]
		&& on_r && en_r[16 + 2 * hsEp] |=> irq; endproperty
	a_dout: assert property (p_dout) else $error("no out irq");
endmodule
bind usb_irq_enable usb_irq_enable_props #(.EP_BITS(EP_BITS)) props_inst (
	.ref_clk(ref_clk), .reset_n(reset_n), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .prdata(prdata), .busResetEvt(busResetEvt),
	.sofEvt(sofEvt), .hsValid(hsValid), .hsEp(hsEp),
	.hsIn(hsIn), .hsNak(hsNak), .irq(irq)
);

// ### test/usb_bus_model.sv
// usb side model: bus event pulses and engine handshakes
`timescale 1ns/100ps
module usb_bus_model (
	input wire ref_clk,
	output logic [5:0] evt,
	output logic hsValid,
	output logic [2:0] hsEp,
	output logic hsIn,
	output logic hsSetup,
	output logic hsNak
);
	initial begin
		evt = 6'h00;
		hsValid = 1'h0;
		{hsEp, hsIn, hsSetup, hsNak} = 6'h00;
	end
	task automatic pulse_evt(input int i);
		@(posedge ref_clk);
		evt <= 6'h01 << i;
		@(posedge ref_clk);
		evt <= 6'h00;
	endtask
	task automatic pulse_hs(input logic [2:0] e, input logic i, s, n);
		@(posedge ref_clk);
		hsValid <= 1'h1;
		{hsEp, hsIn, hsSetup, hsNak} <= {e, i, s, n};
		@(posedge ref_clk);
		hsValid <= 1'h0;
		// idle lines carry junk so ignoring hsValid shows up
		{hsEp, hsIn, hsSetup, hsNak} <= ~{e, i, s, n};
	endtask
endmodule

// ### test/testbench.sv
// self-checking bench for the interrupt enable block
`timescale 1ns/100ps
module testbench;
	logic ref_clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] q;
	logic err;
	int mismatches = 0, checks_done = 0;
	wire pready, pslverr, irq, hsValid, hsIn, hsSetup, hsNak;
	wire [31:0] prdata;
	wire [5:0] evt;
	wire [2:0] hsEp;
	usb_bus_model usb_bus_model_inst (.ref_clk(ref_clk), .evt(evt),
		.hsValid(hsValid), .hsEp(hsEp), .hsIn(hsIn), .hsSetup(hsSetup),
		.hsNak(hsNak));
	usb_irq_enable usb_irq_enable_inst (.ref_clk(ref_clk),
		.reset_n(reset_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
		.pslverr(pslverr), .prdata(prdata), .busResetEvt(evt[0]),
		.sofEvt(evt[1]), .suspendEvt(evt[2]), .resumeEvt(evt[3]),
		.setupEvt(evt[4]), .hsStatusEvt(evt[5]), .hsValid(hsValid),
		.hsEp(hsEp), .hsIn(hsIn), .hsSetup(hsSetup), .hsNak(hsNak),
		.irq(irq));
	initial begin
		forever #20 ref_clk = ~ref_clk;
	end
	////////////////////////////////////////////////////////////
	task chk(input logic [31:0] g, e);
		checks_done++;
		if (g !== e) begin
			mismatches++;
			$display("BAD %0t got %h want %h", $time, g, e);
		end
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		{psel, pwrite, paddr, pwdata} <= {1'h1, w, a, d};
		@(posedge ref_clk);
		penable <= 1'h1;
		do @(posedge ref_clk); while (pready !== 1'h1);
		q = prdata;
		err = pslverr;
		{psel, penable} <= 2'h0;
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e);
		apb(1'h0, a, 32'h00000000);
		chk(q, e);
	endtask
	// irq is a registered level, so look after the edge has settled
	task irq_is(input logic e);
		@(negedge ref_clk);
		chk({31'h0, irq}, {31'h0, e});
	endtask
	task end_of_test;
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		#200000;
		mismatches++;
		end_of_test;
	end
	////////////////////////////////////////////////////////////
	initial begin
		repeat (10) @(posedge ref_clk);
		reset_n <= 1'h1;
		rd(8'h14, 32'h00000000);
		apb(1'h1, 8'h14, 32'hFFFFFFFF);
		rd(8'h14, 32'hFFFFFFFF);
		chk({31'h0, err}, 32'h00000000);
		rd(8'h40, 32'h00000000);
		chk({31'h0, err}, 32'h00000001);
		usb_bus_model_inst.pulse_evt(1);
		irq_is(1'h0);
		apb(1'h1, 8'h0C, 32'h00000001);
		irq_is(1'h1);
		apb(1'h1, 8'h14, 32'h00000000);
		irq_is(1'h0);
		apb(1'h1, 8'h14, 32'hFFFFFFFF);
		for (int i = 1; i < 6; i++) begin
			apb(1'h1, 8'h18, 32'hFFFFFFFF);
			usb_bus_model_inst.pulse_evt(i);
			rd(8'h1C, 32'h00000001 << i);
		end
		// ep0 passes ack, data in passes nak, data out passes both
		apb(1'h1, 8'h10, 32'h00000039);
		for (int i = 0; i < 32; i++) begin
			apb(1'h1, 8'h18, 32'hFFFFFFFF);
			usb_bus_model_inst.pulse_hs(i[4:2], i[1], 1'h0, i[0]);
			rd(8'h1C, (i[4:2] == 0 ? !i[0] : !i[1] || i[0]) ?
				32'h00010000 << (2 * i[4:2] + i[1]) : 32'h0);
		end
		apb(1'h1, 8'h18, 32'hFFFFFFFF);
		usb_bus_model_inst.pulse_hs(3'h0, 1'h0, 1'h1, 1'h0);
		rd(8'h1C, 32'h00010000);
		usb_bus_model_inst.pulse_evt(0);
		rd(8'h14, 32'h00000001);
		irq_is(1'h1);
		apb(1'h1, 8'h14, 32'h00010001);
		rd(8'h1C, 32'h00010001);
		apb(1'h1, 8'h0C, 32'h00000000);
		irq_is(1'h0);
		end_of_test;
	end
endmodule
